// ### mbd_bus.sv
// Purpose: external program memory bus sequencer
// Assumes: fetch request one cycle, address then data phase
// Notes: address low/high pins are three-signal pins
`timescale 1ns/1ps
module mbd_bus
  import mbd_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Fetch side
  input wire logic start,
  input wire logic use_ext,
  input wire logic [15:0] addr,
  output logic done,
  output logic [15:0] ext_word,
  // Pins
  input wire logic [15:0] ad_in,
  output logic [15:0] ad_out,
  output logic [15:0] ad_oe_n,
  output logic [2:0] ctl_out
);
  mbd_bus_e st_q;
  logic [15:0] ad_in_s1_q;
  logic [15:0] ad_in_s2_q;
  logic ph1_q; // Data phase seen one edge ago
  logic ph2_q; // Returned word now through both sync stages
  logic ext_q; // Current cycle has external memory as source

  // Two-stage sync of returned data
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ad_in_s1_q <= 16'h0000;
      ad_in_s2_q <= 16'h0000;
    end else begin
      ad_in_s1_q <= ad_in;
      ad_in_s2_q <= ad_in_s1_q;
    end
  end

  // Phase sequencer: address phase, then data phase
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_q <= MBD_BUS_IDLE;
    end else begin
      unique case (st_q)
        MBD_BUS_IDLE: if (start) st_q <= MBD_BUS_ADDR;
        MBD_BUS_ADDR: st_q <= MBD_BUS_DATA;
        MBD_BUS_DATA: st_q <= MBD_BUS_IDLE;
        default: st_q <= MBD_BUS_IDLE;
      endcase
    end
  end

  // Address drive and strobes; latch enable, output enable, write
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ad_out <= 16'h0000;
      ad_oe_n <= 16'hFFFF;
      ctl_out <= 3'b000;
    end else begin
      ad_oe_n <= 16'hFFFF;
      ctl_out <= 3'b000;
      if (st_q == MBD_BUS_IDLE && start) begin
        ad_out <= addr;
        ad_oe_n <= 16'h0000;
        ctl_out <= 3'b001;
      end else if (st_q == MBD_BUS_ADDR) begin
        ctl_out <= 3'b010;
      end
    end
  end

  // Returned word needs two edges through the sync stages, so done
  // trails the data phase; taking it earlier would return the address
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ph1_q <= 1'b0;
      ph2_q <= 1'b0;
      ext_q <= 1'b0;
    end else begin
      ph1_q <= (st_q == MBD_BUS_DATA);
      ph2_q <= ph1_q;
      if (st_q == MBD_BUS_IDLE && start) begin
        ext_q <= use_ext;
      end
    end
  end
  assign done = ph2_q;
  // Bus data ignored unless external memory is the source
  assign ext_word = ext_q ? ad_in_s2_q : 16'h0000;
endmodule

// ### mbd_ext_mem.sv
// Purpose: external program memory behind address latches
// Assumes: strobe bit0 latches address, bit1 enables memory output
// Notes: word stored is address xor a fixed pattern
`timescale 1ns/1ps
module mbd_ext_mem (
  // Clock
  input wire logic clock,
  // Device pins
  input wire logic [15:0] ad_out,
  input wire logic [15:0] ad_oe_n,
  input wire logic [2:0] ctl,
  // Resolved bus
  output logic [15:0] ad_bus
);
  logic [15:0] addr_q = 16'h0000; // Latched address
  logic drive_q = 1'b0; // Output enabled since read strobe
  logic [15:0] lat; // Transparent latch view
  logic [15:0] word; // Memory word
  logic drive; // Memory drives the bus
  assign lat = ctl[0] ? ad_out : addr_q;
  assign word = lat ^ 16'hC35A;
  // Never drive while the device holds an address
  assign drive = (drive_q || ctl[1]) && !ctl[0] && &ad_oe_n;
  // Latch address, keep output until next address strobe
  always_ff @(posedge clock) begin
    if (ctl[0]) begin
      addr_q <= ad_out;
      drive_q <= 1'b0;
    end else if (ctl[1]) begin
      drive_q <= 1'b1;
    end
  end
  // Released lines show the inverse so stale data never matches
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (!ad_oe_n[i]) ad_bus[i] = ad_out[i];
      else ad_bus[i] = drive ? word[i] : ~word[i];
    end
  end
endmodule

// ### mbd_params.svh
// Purpose: constants for the memory map and bank decode block
// Assumes: 8-bit data space, 16-bit program address
// Notes: offsets are data-space addresses of the core registers
// Function
// - Mode decides internal and protected area access
// - Unprogrammed device starts in external-only mode
// - Data accesses always stay on chip
// - External modes build muxed 16-bit bus, control bits
// - Extended mode mirrors internal fetches, ignores bus data
// - Data space split; general RAM banked from 20 up
// - Unbanked addresses ignore bank select entirely
// - Peripheral range 00-1F, file range 00-FF
// - 1A-1F are six unbanked general RAM bytes
// - Pointer accesses use same bank bits as direct
// - General RAM 8 bits, never touched by reset
// - Core regs unbanked; instruction loads peripheral bank
// - 10-17 banked by low nibble of bank select
// - 20-FF banked into four ranges by upper nibble
// - Unimplemented registers read as zeros
// - Extended mode switches internal/external by fetch address
// - Internal-only modes: no bus cycle, undefined beyond
`ifndef MBD_PARAMS_SVH
`define MBD_PARAMS_SVH
// -----------------------------
// Register offsets
// -----------------------------
`define MBD_ADDR_WIN0 8'h00
`define MBD_ADDR_PTR0 8'h01
`define MBD_ADDR_WIN1 8'h08
`define MBD_ADDR_PTR1 8'h09
`define MBD_ADDR_BSEL 8'h0F
`define MBD_BSEL_RESET 8'h00
// -----------------------------
// Region limits
// -----------------------------
`define MBD_SFR_BANK_LO 8'h10
`define MBD_SFR_BANK_HI 8'h17
`define MBD_GPR_UNB_LO 8'h1A
`define MBD_GPR_UNB_HI 8'h1F
`define MBD_PERIPH_HI 8'h1F
`define MBD_GPR_BANK_LO 8'h20
// Number of implemented RAM banks (3 on small parts)
`define MBD_RAM_BANKS 3'd4
// Internal program memory size in words (last address)
`define MBD_INT_PM_LAST 16'h3FFF
`endif

// ### mbd_pkg.sv
// Purpose: types for the memory map and bank decode block
// Assumes: mbd_params.svh holds the numbers
// Notes: mode codes match the two configuration bits
package mbd_pkg;
  // Program memory modes; 2'b00 is what an erased part reads as
  typedef enum logic [1:0] {
    MBD_MODE_EXT_ONLY = 2'b00,
    MBD_MODE_EXTENDED = 2'b01,
    MBD_MODE_INT_PROT = 2'b10,
    MBD_MODE_INT_ONLY = 2'b11
  } mbd_mode_e;
  // Bus cycle phase
  typedef enum logic [1:0] {
    MBD_BUS_IDLE = 2'b00,
    MBD_BUS_ADDR = 2'b01,
    MBD_BUS_DATA = 2'b10
  } mbd_bus_e;
endpackage

// ### mbd_ram.sv
// Purpose: general RAM storage, 8 bits wide, registered read
// Assumes: one access per cycle
// Notes: no reset on the array so contents survive every reset
`timescale 1ns/1ps
module mbd_ram (
  // Clock
  input wire logic clock,
  // Access
  input wire logic [9:0] addr,
  input wire logic we,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  // Storage array, 1 KiB space
  logic [7:0] mem_q [0:1023];

  // Write and registered read, array never reset
  always_ff @(posedge clock) begin
    if (we) begin
      mem_q[addr] <= wdata;
    end
    rdata <= mem_q[addr];
  end
endmodule

// ### mbd_top.sv
// Purpose: program memory mode gating and data memory bank decode
// Assumes: core gives one data access and one fetch request at a time
// Notes: peripheral banks are reached through a port to the peripherals
`timescale 1ns/1ps
`include "mbd_params.svh"
module mbd_top
  import mbd_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Configuration bits
  input wire logic [1:0] cfg_mode,
  // Core data access
  input wire logic [7:0] d_addr,
  input wire logic d_rd,
  input wire logic d_wr,
  input wire logic [7:0] d_wdata,
  input wire logic [1:0] d_indirect,
  output logic [7:0] d_rdata,
  // Bank load instructions
  input wire logic load_periph_bank,
  input wire logic load_ram_bank,
  input wire logic [3:0] bank_lit,
  // Peripheral register port
  output logic [3:0] periph_bank,
  output logic [2:0] periph_idx,
  output logic periph_rd,
  output logic periph_wr,
  input wire logic [7:0] periph_rdata,
  input wire logic periph_hit,
  // Program fetch
  input wire logic f_req,
  input wire logic [15:0] f_addr,
  input wire logic [15:0] int_pm_data,
  output logic int_pm_rd,
  output logic [15:0] f_data,
  output logic f_valid,
  // Protected area access
  input wire logic prot_req,
  output logic prot_allow,
  // Mode status
  output logic [1:0] mode,
  // External bus pins
  input wire logic [7:0] addr_data_low_port_in,
  output logic [7:0] addr_data_low_port_out,
  output logic [7:0] addr_data_low_port_oe_n,
  input wire logic [7:0] addr_data_high_port_in,
  output logic [7:0] addr_data_high_port_out,
  output logic [7:0] addr_data_high_port_oe_n,
  output logic [2:0] bus_control_port
);
  // -----------------------------
  // State
  // -----------------------------
  mbd_mode_e mode_q; // Latched program mode
  logic mode_taken_q; // Mode captured since reset release
  logic [7:0] bsel_q; // Bank select register
  logic [7:0] ptr0_q; // Pointer 0
  logic [7:0] ptr1_q; // Pointer 1
  logic [7:0] ea; // Effective address after indirection
  logic [9:0] ram_addr; // Flat RAM address
  logic ram_hit; // Access lands in general RAM
  logic ram_impl; // RAM bank implemented
  logic sfr_bank_hit; // Access lands in banked SFRs
  logic core_hit; // Access lands in core registers
  logic [7:0] ram_rdata;
  logic [7:0] core_rdata_q;
  logic [7:0] periph_rdata_q;
  logic [1:0] src_q; // Read source for returned data
  logic [15:0] ext_word;
  logic bus_done;
  logic ext_fetch; // Fetch served externally
  logic bus_start;
  logic int_fetch_q; // Internal fetch in flight
  logic [15:0] int_word_q;
  logic [15:0] ad_out;
  logic [15:0] ad_oe_n;
  logic [2:0] ctl;
  logic ext_modes; // Bus modes active

  // -----------------------------
  // Mode capture
  // -----------------------------
  // Erased config reads as external-only, also the reset value
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mode_q <= MBD_MODE_EXT_ONLY;
      mode_taken_q <= 1'b0;
    end else if (!mode_taken_q) begin
      mode_q <= mbd_mode_e'(cfg_mode);
      mode_taken_q <= 1'b1;
    end
  end
  assign mode = mode_q;

  // Protected areas reachable only in the internal-only modes
  assign prot_allow = prot_req &&
    (mode_q == MBD_MODE_INT_ONLY || mode_q == MBD_MODE_INT_PROT);

  // -----------------------------
  // Data address decode
  // -----------------------------
  // Pointer windows redirect through their pointers
  always_comb begin
    ea = d_addr;
    if (d_indirect == 2'b01) begin
      ea = ptr0_q;
    end else if (d_indirect == 2'b10) begin
      ea = ptr1_q;
    end
  end

  // Region classification, data always on chip whatever the mode
  assign core_hit = ea < `MBD_SFR_BANK_LO;
  assign sfr_bank_hit = ea >= `MBD_SFR_BANK_LO && ea <= `MBD_SFR_BANK_HI;
  assign ram_hit = (ea >= `MBD_GPR_UNB_LO && ea <= `MBD_GPR_UNB_HI) ||
    ea >= `MBD_GPR_BANK_LO;

  // Unbanked bytes ignore bank select; banked ones use upper nibble
  always_comb begin
    if (ea < `MBD_GPR_BANK_LO) begin
      ram_addr = {2'b00, ea};
    end else begin
      ram_addr = {bsel_q[5:4], ea};
    end
  end
  // Upper nibble beyond implemented banks reads zero and drops writes
  assign ram_impl = (ea < `MBD_GPR_BANK_LO) ||
    ({1'b0, bsel_q[5:4]} < `MBD_RAM_BANKS && bsel_q[7:6] == 2'b00);

  // Peripheral port uses only the low nibble
  assign periph_bank = bsel_q[3:0];
  assign periph_idx = ea[2:0];
  assign periph_rd = d_rd && sfr_bank_hit;
  assign periph_wr = d_wr && sfr_bank_hit;

  mbd_ram u_ram (
    .clock(clock),
    .addr(ram_addr),
    .we(d_wr && ram_hit && ram_impl),
    .wdata(d_wdata),
    .rdata(ram_rdata)
  );

  // -----------------------------
  // Core registers
  // -----------------------------
  // Bank select: direct writes and the two load instructions
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      bsel_q <= `MBD_BSEL_RESET;
    end else if (load_periph_bank) begin
      bsel_q[3:0] <= bank_lit;
    end else if (load_ram_bank) begin
      bsel_q[7:4] <= bank_lit;
    end else if (d_wr && ea == `MBD_ADDR_BSEL) begin
      bsel_q <= d_wdata;
    end
  end

  // Pointers; hold through reset is allowed, cleared for determinism
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ptr0_q <= 8'h00;
      ptr1_q <= 8'h00;
    end else if (d_wr) begin
      if (ea == `MBD_ADDR_PTR0) ptr0_q <= d_wdata;
      if (ea == `MBD_ADDR_PTR1) ptr1_q <= d_wdata;
    end
  end

  // Registered read of core and peripheral sources
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      core_rdata_q <= 8'h00;
      periph_rdata_q <= 8'h00;
      src_q <= 2'b00;
    end else begin
      src_q <= 2'b00;
      if (d_rd) begin
        if (ram_hit && ram_impl) begin
          src_q <= 2'b01;
        end else if (sfr_bank_hit) begin
          src_q <= 2'b10;
          periph_rdata_q <= periph_hit ? periph_rdata : 8'h00;
        end else if (core_hit) begin
          src_q <= 2'b11;
          unique case (ea)
            `MBD_ADDR_PTR0: core_rdata_q <= ptr0_q;
            `MBD_ADDR_PTR1: core_rdata_q <= ptr1_q;
            `MBD_ADDR_BSEL: core_rdata_q <= bsel_q;
            default: core_rdata_q <= 8'h00;
          endcase
        end
      end
    end
  end

  // Return mux; unmatched sources give zero
  always_comb begin
    unique case (src_q)
      2'b01: d_rdata = ram_rdata;
      2'b10: d_rdata = periph_rdata_q;
      2'b11: d_rdata = core_rdata_q;
      default: d_rdata = 8'h00;
    endcase
  end

  // -----------------------------
  // Program fetch
  // -----------------------------
  assign ext_modes = mode_q == MBD_MODE_EXT_ONLY || mode_q == MBD_MODE_EXTENDED;
  // External source chosen by mode and fetch address
  assign ext_fetch = mode_q == MBD_MODE_EXT_ONLY ||
    (mode_q == MBD_MODE_EXTENDED && f_addr > `MBD_INT_PM_LAST);
  // Bus cycles run for every fetch in bus modes, none otherwise
  assign bus_start = f_req && ext_modes;
  assign int_pm_rd = f_req && !ext_fetch;

  mbd_bus u_bus (
    .clock(clock),
    .rstn(rstn),
    .start(bus_start),
    .use_ext(ext_fetch),
    .addr(f_addr),
    .done(bus_done),
    .ext_word(ext_word),
    .ad_in({addr_data_high_port_in, addr_data_low_port_in}),
    .ad_out(ad_out),
    .ad_oe_n(ad_oe_n),
    .ctl_out(ctl)
  );

  // Pin split; bus released (oe_n high) outside address phase
  assign addr_data_low_port_out = ad_out[7:0];
  assign addr_data_high_port_out = ad_out[15:8];
  assign addr_data_low_port_oe_n = ad_oe_n[7:0];
  assign addr_data_high_port_oe_n = ad_oe_n[15:8];
  assign bus_control_port = ctl;

  // Internal word tracking; in bus modes wait for the mirrored cycle
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      int_fetch_q <= 1'b0;
      int_word_q <= 16'h0000;
    end else begin
      if (int_pm_rd) begin
        int_fetch_q <= 1'b1;
        int_word_q <= int_pm_data;
      end else if (f_valid) begin
        int_fetch_q <= 1'b0;
      end
    end
  end

  // Fetch result: external word only when external was the source
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      f_data <= 16'h0000;
      f_valid <= 1'b0;
    end else begin
      f_valid <= 1'b0;
      if (ext_modes && bus_done) begin
        f_valid <= 1'b1;
        f_data <= int_fetch_q ? int_word_q : ext_word;
      end else if (!ext_modes && int_pm_rd) begin
        f_valid <= 1'b1;
        f_data <= int_pm_data;
      end
    end
  end
endmodule

// ### mbd_top_monitor.sv
// Purpose: concurrent checks on the decode block ports
// Assumes: one clock domain, async low reset
// Notes: bus walk checked cycle by cycle
`timescale 1ns/1ps
module mbd_top_monitor (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Data side
  input wire logic [7:0] d_addr,
  input wire logic d_rd,
  input wire logic d_wr,
  input wire logic [1:0] d_indirect,
  input wire logic [7:0] d_rdata,
  input wire logic load_periph_bank,
  input wire logic [3:0] bank_lit,
  input wire logic [3:0] periph_bank,
  input wire logic [2:0] periph_idx,
  input wire logic periph_rd,
  input wire logic periph_wr,
  input wire logic [7:0] periph_rdata,
  input wire logic periph_hit,
  // Fetch and mode
  input wire logic f_req,
  input wire logic [15:0] f_addr,
  input wire logic [15:0] int_pm_data,
  input wire logic int_pm_rd,
  input wire logic [15:0] f_data,
  input wire logic f_valid,
  input wire logic prot_req,
  input wire logic prot_allow,
  input wire logic [1:0] mode,
  // Bus pins
  input wire logic [7:0] addr_data_low_port_out,
  input wire logic [7:0] addr_data_low_port_oe_n,
  input wire logic [7:0] addr_data_high_port_out,
  input wire logic [7:0] addr_data_high_port_oe_n,
  input wire logic [2:0] bus_control_port
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // Direct read of a banked peripheral slot
  logic per_rd;
  assign per_rd = d_rd && d_indirect == 2'b00 && d_addr >= 8'h10 && d_addr <= 8'h17;
  // Direct write of a banked peripheral slot
  logic per_wr;
  assign per_wr = d_wr && d_indirect == 2'b00 && d_addr >= 8'h10 && d_addr <= 8'h17;
  // Bus cycle phases
  sequence s_addr_ph;
    bus_control_port == 3'b001 && addr_data_low_port_oe_n == 8'h00
      && addr_data_high_port_oe_n == 8'h00;
  endsequence
  sequence s_data_ph;
    bus_control_port == 3'b010 && &addr_data_low_port_oe_n && &addr_data_high_port_oe_n;
  endsequence
  sequence s_done_ph;
    bus_control_port == 3'b000 [*2] ##1 f_valid;
  endsequence
  AST_BUS_WALK: assert property (!mode[1] && f_req |=> s_addr_ph ##1 s_data_ph ##1 s_done_ph)
    else $error("bus walk wrong");
  AST_BUS_ADDR: assert property (!mode[1] && f_req |=>
    {addr_data_high_port_out, addr_data_low_port_out} == $past(f_addr)) else $error("bus address");
  AST_INT_FETCH: assert property (mode[1] && f_req |=>
    f_valid && f_data == $past(int_pm_data)) else $error("internal fetch");
  AST_NO_BUS: assert property (mode[1] |-> bus_control_port == 3'b000
    && &addr_data_low_port_oe_n && &addr_data_high_port_oe_n) else $error("bus active");
  AST_NO_INT: assert property (mode == 2'b00 |-> !int_pm_rd)
    else $error("internal read in external mode");
  AST_PROT: assert property (prot_allow == (prot_req && mode[1]))
    else $error("protected gate");
  AST_MODE_HOLD: assert property ($past(rstn, 2) |-> $stable(mode))
    else $error("mode moved");
  AST_PERIPH: assert property (per_rd |-> periph_rd && periph_idx == d_addr[2:0])
    else $error("peripheral strobe");
  AST_PHIT: assert property (per_rd |=>
    d_rdata == ($past(periph_hit) ? $past(periph_rdata) : 8'h00)) else $error("peripheral data");
  AST_PBANK: assert property (load_periph_bank |=> periph_bank == $past(bank_lit))
    else $error("peripheral bank");
  AST_PWR: assert property (per_wr |-> periph_wr && !periph_rd)
    else $error("peripheral write strobe");
endmodule
bind mbd_top mbd_top_monitor u_mon (.clock(clock), .rstn(rstn), .d_addr(d_addr), .d_rd(d_rd),
  .d_wr(d_wr), .periph_wr(periph_wr),
  .d_indirect(d_indirect), .d_rdata(d_rdata), .load_periph_bank(load_periph_bank),
  .bank_lit(bank_lit), .periph_bank(periph_bank), .periph_idx(periph_idx),
  .periph_rd(periph_rd), .periph_rdata(periph_rdata), .periph_hit(periph_hit), .f_req(f_req),
  .f_addr(f_addr), .int_pm_data(int_pm_data), .int_pm_rd(int_pm_rd), .f_data(f_data),
  .f_valid(f_valid), .prot_req(prot_req), .prot_allow(prot_allow), .mode(mode),
  .addr_data_low_port_out(addr_data_low_port_out),
  .addr_data_low_port_oe_n(addr_data_low_port_oe_n),
  .addr_data_high_port_out(addr_data_high_port_out),
  .addr_data_high_port_oe_n(addr_data_high_port_oe_n), .bus_control_port(bus_control_port));

// ### memory_map_and_bank_decode_test.sv
// Purpose: directed test of mode gating and bank decode
// Assumes: external memory model returns address xor C35A
// Notes: internal word is the byte-swapped fetch address
`timescale 1ns/1ps
module memory_map_and_bank_decode_test;
  logic clock, rstn, d_rd, d_wr, load_periph_bank, load_ram_bank, periph_rd, periph_wr;
  logic periph_hit, f_req, int_pm_rd, f_valid, prot_req, prot_allow;
  logic [1:0] cfg_mode, d_indirect, mode;
  logic [7:0] d_addr, d_wdata, d_rdata, periph_rdata, lo_out, lo_oe_n, hi_out, hi_oe_n;
  logic [3:0] bank_lit, periph_bank;
  logic [2:0] periph_idx, ctl;
  logic [15:0] f_addr, int_pm_data, f_data, ad_bus;
  int errors = 0;
  int num_checks = 0;
  assign int_pm_data = {f_addr[7:0], f_addr[15:8]};
  assign periph_rdata = {periph_bank, 1'b0, periph_idx};
  mbd_top dut (.clock(clock), .rstn(rstn), .cfg_mode(cfg_mode), .d_addr(d_addr), .d_rd(d_rd),
    .d_wr(d_wr), .d_wdata(d_wdata), .d_indirect(d_indirect), .d_rdata(d_rdata),
    .load_periph_bank(load_periph_bank), .load_ram_bank(load_ram_bank), .bank_lit(bank_lit),
    .periph_bank(periph_bank), .periph_idx(periph_idx), .periph_rd(periph_rd),
    .periph_wr(periph_wr), .periph_rdata(periph_rdata), .periph_hit(periph_hit),
    .f_req(f_req), .f_addr(f_addr), .int_pm_data(int_pm_data), .int_pm_rd(int_pm_rd),
    .f_data(f_data), .f_valid(f_valid), .prot_req(prot_req), .prot_allow(prot_allow),
    .mode(mode), .addr_data_low_port_in(ad_bus[7:0]), .addr_data_low_port_out(lo_out),
    .addr_data_low_port_oe_n(lo_oe_n), .addr_data_high_port_in(ad_bus[15:8]),
    .addr_data_high_port_out(hi_out), .addr_data_high_port_oe_n(hi_oe_n),
    .bus_control_port(ctl));
  mbd_ext_mem mem (.clock(clock), .ad_out({hi_out, lo_out}), .ad_oe_n({hi_oe_n, lo_oe_n}),
    .ctl(ctl), .ad_bus(ad_bus));
  // 40 MHz clock
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk16(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Reset with a mode on the configuration pins, then confirm it
  task automatic do_reset(input logic [1:0] m);
    @(posedge clock);
    rstn <= 1'b0;
    cfg_mode <= m;
    repeat (16) @(posedge clock);
    rstn <= 1'b1;
    repeat (2) @(posedge clock);
    #1;
    chk8({6'h00, mode}, {6'h00, m});
  endtask
  // Data access, one-cycle strobe
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] v,
                        input logic [1:0] ind);
    @(posedge clock);
    d_addr <= a;
    d_wdata <= v;
    d_indirect <= ind;
    d_wr <= w;
    d_rd <= !w;
    @(posedge clock);
    d_wr <= 1'b0;
    d_rd <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] ind, input logic [7:0] e);
    access(1'b0, a, 8'h00, ind);
    chk8(d_rdata, e);
  endtask
  // Bank load: ram selects the upper nibble
  task automatic ldb(input logic ram, input logic [3:0] v);
    @(posedge clock);
    load_ram_bank <= ram;
    load_periph_bank <= !ram;
    bank_lit <= v;
    @(posedge clock);
    load_ram_bank <= 1'b0;
    load_periph_bank <= 1'b0;
  endtask
  // Fetch with bounded wait on the valid pulse
  task automatic fetch(input logic [15:0] a, input logic [15:0] e, input logic c);
    @(posedge clock);
    f_req <= 1'b1;
    f_addr <= a;
    @(posedge clock);
    f_req <= 1'b0;
    #1;
    for (int i = 0; i < 8 && f_valid !== 1'b1; i++) begin
      @(posedge clock);
      #1;
    end
    if (f_valid !== 1'b1) begin
      errors++;
      tally_and_finish();
    end
    if (c) chk16(f_data, e);
  endtask
  initial begin
    {rstn, d_rd, d_wr, load_periph_bank, load_ram_bank, periph_hit, f_req, prot_req} = 8'h00;
    {cfg_mode, d_indirect, d_addr, d_wdata, bank_lit, f_addr} = 40'h0;
    do_reset(2'b00);
    prot_req <= 1'b1;
    fetch(16'h0010, 16'h0010 ^ 16'hC35A, 1'b1);
    chk8({7'h00, prot_allow}, 8'h00);
    // Four RAM banks at the same offset, then an unimplemented bank
    for (int b = 0; b < 4; b++) begin
      ldb(1'b1, 4'(b));
      access(1'b1, 8'h20, 8'hA0 + 8'(b), 2'b00);
    end
    for (int b = 0; b < 4; b++) begin
      ldb(1'b1, 4'(b));
      rd(8'h20, 2'b00, 8'hA0 + 8'(b));
    end
    ldb(1'b1, 4'h4);
    access(1'b1, 8'h20, 8'h77, 2'b00);
    rd(8'h20, 2'b00, 8'h00);
    ldb(1'b1, 4'h0);
    rd(8'h20, 2'b00, 8'hA0);
    // Unbanked RAM, unimplemented 18 and bank select readback
    access(1'b1, 8'h1A, 8'h5C, 2'b00);
    ldb(1'b1, 4'h3);
    rd(8'h1A, 2'b00, 8'h5C);
    rd(8'h18, 2'b00, 8'h00);
    ldb(1'b0, 4'h6);
    rd(8'h0F, 2'b00, 8'h36);
    // Pointer accesses through the current RAM bank
    access(1'b1, 8'h09, 8'h20, 2'b00);
    rd(8'h08, 2'b10, 8'hA3);
    access(1'b1, 8'h01, 8'h21, 2'b00);
    access(1'b1, 8'h00, 8'h99, 2'b01);
    rd(8'h21, 2'b00, 8'h99);
    // Peripheral slot with and without a responder
    access(1'b1, 8'h15, 8'h42, 2'b00);
    periph_hit <= 1'b1;
    rd(8'h13, 2'b00, 8'h63);
    periph_hit <= 1'b0;
    rd(8'h17, 2'b00, 8'h00);
    // RAM survives a reset
    do_reset(2'b00);
    rd(8'h20, 2'b00, 8'hA0);
    // Extended mode: internal words mirrored on the bus, high words external
    do_reset(2'b01);
    cfg_mode <= 2'b11;
    fetch(16'h1234, 16'h3412, 1'b1);
    fetch(16'h8000, 16'h8000 ^ 16'hC35A, 1'b1);
    chk8({6'h00, mode}, 8'h01);
    chk8({7'h00, prot_allow}, 8'h00);
    // Both internal-only modes
    for (int m = 2; m < 4; m++) begin
      do_reset(2'(m));
      fetch(16'h0100, 16'h0001, 1'b1);
      fetch(16'hF000, 16'h0000, 1'b0);
      chk8({7'h00, prot_allow}, 8'h01);
      chk8({5'h00, ctl}, 8'h00);
    end
    tally_and_finish();
  end
endmodule
